// file: hw/uart_async_receiver.sv
/*
 * Asynchronous serial receiver with a two-character receive buffer,
 * start-bit noise rejection, majority voting and parity checking.
 * Assumes a one-cycle sample tick from an outside baud generator at
 * 16x (or 8x in double speed) the bit rate, and a CPU on a plain
 * register port with read data one cycle after the read strobe.
 */
`timescale 1ns/100ps
`include "uart_rx_defs.svh"

module uart_async_receiver
	import uart_rx_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// Oversampling tick from the baud generator
	input  wire logic       sample_tick_in,
	// Serial line
	input  wire logic       serial_input_pin_in,
	// Register port
	input  wire logic [1:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	// Status towards the system
	output logic            rx_irq_out,
	output logic            pin_override_out
);

	// Reset images; a literal cannot be bit-selected directly
	localparam logic [7:0] RESET_A = `RST_STATUS_A;
	localparam logic [7:0] RESET_B = `RST_CONTROL_B;
	localparam logic [7:0] RESET_C = `RST_CONTROL_C;

	// Synchroniser stages
	logic            rx_meta_reg;
	logic            rx_sync_reg;
	// Software registers
	logic            rx_complete_irq_enable;
	logic            receiver_enable_bit;
	logic            double_speed_bit;
	logic            parity_mode_high;
	logic            parity_mode_low;
	logic            stop_bit_select;
	logic      [1:0] char_size_reg;
	// Recovery machine
	rx_state_e       state_reg;
	logic      [4:0] cnt_reg;
	logic      [1:0] votes_reg;
	logic            last_smp_reg;
	logic      [2:0] bit_idx_reg;
	logic      [7:0] shift_reg;
	logic            par_err_reg;
	logic            lose_reg;
	// Waiting character and buffer
	logic            pend_valid_reg;
	rx_entry_s       pend_reg;
	rx_entry_s       buf_mem [2];
	logic            rd_ptr_reg;
	logic      [1:0] count_reg;
	logic            dor_sticky_reg;

	// Decode and derived timing
	logic      [4:0] bit_len;
	logic      [4:0] vote_first;
	logic      [4:0] vote_last;
	logic            decide;
	logic            bit_val;
	logic      [2:0] last_idx;
	logic            pop;
	logic            push;
	logic            wr_idx;
	logic            ovr_set;
	logic            start_ok;
	rx_entry_s       head;

	// Two-flop synchroniser on the serial pin
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
		end else begin
			rx_meta_reg <= serial_input_pin_in;
			rx_sync_reg <= rx_meta_reg;
		end
	end

	// Sampling rate and vote window
	always_comb begin
		bit_len    = double_speed_bit ? `SPB_DOUBLE : `SPB_NORMAL;
		vote_first = double_speed_bit ? `VOTE_DOUBLE : `VOTE_NORMAL;
		vote_last  = vote_first + 5'h02;
		decide     = sample_tick_in && (cnt_reg == vote_last);
		// Two of three wins, current sample is the third
		bit_val    = (votes_reg[1] & votes_reg[0]) | (rx_sync_reg & (votes_reg[1] | votes_reg[0]));
		last_idx   = {1'b1, char_size_reg};
	end

	// Buffer bookkeeping terms
	always_comb begin
		pop      = rd_in && (addr_in == `OFS_DATA) && (count_reg != 2'h0);
		push     = pend_valid_reg && ((count_reg != `BUF_DEPTH) || pop);
		wr_idx   = rd_ptr_reg ^ count_reg[0];
		start_ok = (state_reg == ST_START) && decide && !bit_val;
		// Full buffer plus a waiting character means the new frame is lost
		ovr_set  = start_ok && (count_reg == `BUF_DEPTH) && pend_valid_reg;
		head     = buf_mem[rd_ptr_reg];
	end

	// Control registers; status writes only touch double speed
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rx_complete_irq_enable <= RESET_B[`BIT_RXCIE];
			receiver_enable_bit    <= RESET_B[`BIT_RXEN];
			double_speed_bit       <= RESET_A[`BIT_U2X];
			parity_mode_high       <= RESET_C[`BIT_PM_HI];
			parity_mode_low        <= RESET_C[`BIT_PM_LO];
			stop_bit_select        <= RESET_C[`BIT_SBS];
			char_size_reg          <= RESET_C[`BIT_CSZ_HI:`BIT_CSZ_LO];
		end else if (wr_in) begin
			case (addr_in)
				// Error positions are not stored from writes
				`OFS_STATUS_A: begin
					double_speed_bit <= wdata_in[`BIT_U2X];
				end
				`OFS_CONTROL_B: begin
					rx_complete_irq_enable <= wdata_in[`BIT_RXCIE];
					receiver_enable_bit    <= wdata_in[`BIT_RXEN];
				end
				`OFS_CONTROL_C: begin
					parity_mode_high <= wdata_in[`BIT_PM_HI];
					parity_mode_low  <= wdata_in[`BIT_PM_LO];
					stop_bit_select  <= wdata_in[`BIT_SBS];
					char_size_reg    <= wdata_in[`BIT_CSZ_HI:`BIT_CSZ_LO];
				end
				// Data register is read only here
				default: begin
				end
			endcase
		end
	end

	// Sample counter and vote shift, free running within a frame
	always_ff @(posedge clk_in) begin
		if (rst_in || !receiver_enable_bit) begin
			cnt_reg   <= 5'h00;
			votes_reg <= 2'b11;
		end else if (sample_tick_in) begin
			if (state_reg == ST_IDLE) begin
				// The first low sample is one, so the next tick is sample two
				cnt_reg <= 5'h02;
			end else if (cnt_reg == bit_len) begin
				cnt_reg <= 5'h01;
			end else begin
				cnt_reg <= cnt_reg + 5'h01;
			end
			// Collect the centre samples
			if ((cnt_reg >= vote_first) && (cnt_reg < vote_last)) begin
				votes_reg <= {votes_reg[0], rx_sync_reg};
			end
		end
	end

	// Frame recovery state machine
	always_ff @(posedge clk_in) begin
		if (rst_in || !receiver_enable_bit) begin
			// Disable abandons any frame in progress
			state_reg    <= ST_IDLE;
			last_smp_reg <= 1'b0;
			bit_idx_reg  <= 3'h0;
			shift_reg    <= 8'h00;
			par_err_reg  <= 1'b0;
			lose_reg     <= 1'b0;
		end else begin
			case (state_reg)
				// Hunt for a high to low transition
				ST_IDLE: begin
					if (sample_tick_in) begin
						last_smp_reg <= rx_sync_reg;
						if (last_smp_reg && !rx_sync_reg) begin
							state_reg <= ST_START;
						end
					end
				end
				// Validate the start bit
				ST_START: begin
					if (decide) begin
						if (bit_val) begin
							// Noise spike, back to hunting
							state_reg    <= ST_IDLE;
							last_smp_reg <= rx_sync_reg;
						end else begin
							state_reg   <= ST_DATA;
							bit_idx_reg <= 3'h0;
							shift_reg   <= 8'h00;
							par_err_reg <= 1'b0;
							lose_reg    <= ovr_set;
						end
					end
				end
				// Data bits, least significant first
				ST_DATA: begin
					if (decide) begin
						shift_reg[bit_idx_reg] <= bit_val;
						bit_idx_reg            <= bit_idx_reg + 3'h1;
						if (bit_idx_reg == last_idx) begin
							state_reg <= parity_mode_high ? ST_PARITY : ST_STOP;
						end
					end
				end
				// Parity compare against the data bits
				ST_PARITY: begin
					if (decide) begin
						par_err_reg <= parity_mode_high & (^shift_reg ^ bit_val ^ parity_mode_low);
						state_reg   <= ST_STOP;
					end
				end
				// Only the first stop bit is looked at
				ST_STOP: begin
					if (decide) begin
						state_reg    <= ST_IDLE;
						last_smp_reg <= rx_sync_reg;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Shift register to waiting slot; a frame lost to overrun is dropped
	always_ff @(posedge clk_in) begin
		if (rst_in || !receiver_enable_bit) begin
			pend_valid_reg <= 1'b0;
			pend_reg       <= '0;
		end else if ((state_reg == ST_STOP) && decide && !lose_reg) begin
			pend_valid_reg <= 1'b1;
			pend_reg.data  <= shift_reg;
			pend_reg.fe    <= !bit_val;
			pend_reg.pe    <= par_err_reg;
			pend_reg.dor   <= 1'b0;
		end else if (push) begin
			pend_valid_reg <= 1'b0;
		end
	end

	// Overrun memory until a character reaches the buffer
	always_ff @(posedge clk_in) begin
		if (rst_in || !receiver_enable_bit) begin
			dor_sticky_reg <= 1'b0;
		end else if (ovr_set) begin
			// A set in the transfer cycle survives the clear
			dor_sticky_reg <= 1'b1;
		end else if (push) begin
			dor_sticky_reg <= 1'b0;
		end
	end

	// Buffer entries, written at the tail
	for (genvar i = 0; i < 2; i++) begin : g_entry
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				buf_mem[i] <= '0;
			end else if (push && (wr_idx == 1'(i))) begin
				buf_mem[i]     <= pend_reg;
				buf_mem[i].dor <= dor_sticky_reg | ovr_set;
			end
		end
	end

	// Head pointer and fill count
	always_ff @(posedge clk_in) begin
		if (rst_in || !receiver_enable_bit) begin
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end else begin
			if (pop) begin
				rd_ptr_reg <= !rd_ptr_reg;
			end
			// Push and pop together keep the count
			if (push && !pop) begin
				count_reg <= count_reg + 2'h1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 2'h1;
			end
		end
	end

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			case (addr_in)
				`OFS_STATUS_A: begin
					rdata_out <= 8'h00;
					rdata_out[`BIT_RXC] <= (count_reg != 2'h0);
					// Flags describe the next readable character
					rdata_out[`BIT_FE]  <= (count_reg != 2'h0) & head.fe;
					rdata_out[`BIT_DOR] <= (count_reg != 2'h0) & head.dor;
					rdata_out[`BIT_UPE] <= (count_reg != 2'h0) & head.pe;
					rdata_out[`BIT_U2X] <= double_speed_bit;
				end
				`OFS_CONTROL_B: begin
					rdata_out <= 8'h00;
					rdata_out[`BIT_RXCIE] <= rx_complete_irq_enable;
					rdata_out[`BIT_RXEN]  <= receiver_enable_bit;
				end
				`OFS_CONTROL_C: begin
					rdata_out <= 8'h00;
					rdata_out[`BIT_PM_HI] <= parity_mode_high;
					rdata_out[`BIT_PM_LO] <= parity_mode_low;
					rdata_out[`BIT_SBS]   <= stop_bit_select;
					rdata_out[`BIT_CSZ_HI:`BIT_CSZ_LO] <= char_size_reg;
				end
				// Empty buffer reads as zero
				default: begin
					rdata_out <= (count_reg != 2'h0) ? head.data : 8'h00;
				end
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end

	// Interrupt and pin ownership; error flags take no part
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rx_irq_out       <= 1'b0;
			pin_override_out <= 1'b0;
		end else begin
			// Level request, one cycle behind the flag
			rx_irq_out       <= rx_complete_irq_enable && (count_reg != 2'h0);
			pin_override_out <= receiver_enable_bit;
		end
	end

	// Checks on the receive path
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	a_irq_follows_flag: assert property (
		##1 rx_irq_out == $past(rx_complete_irq_enable && (count_reg != 2'h0)))
		else $error("interrupt does not follow complete flag");
	a_disable_flush: assert property (
		!receiver_enable_bit |=> (count_reg == 2'h0) && (state_reg == ST_IDLE) && !pend_valid_reg)
		else $error("disable did not flush");
	a_count_bound: assert property (count_reg <= `BUF_DEPTH)
		else $error("buffer count beyond depth");
	a_pop_advances: assert property (
		(pop && !push) |=> (count_reg == $past(count_reg) - 2'h1) && (rd_ptr_reg != $past(rd_ptr_reg)))
		else $error("data read did not advance buffer");
	a_noise_reject: assert property (
		((state_reg == ST_START) && decide && bit_val) |=> (state_reg == ST_IDLE))
		else $error("noisy start bit not rejected");
	a_stop_frame: assert property (
		((state_reg == ST_STOP) && decide && !lose_reg) |=> (state_reg == ST_IDLE) && pend_valid_reg
		&& (pend_reg.fe == !$past(bit_val)))
		else $error("stop bit not handled");
	a_overrun_seen: assert property (ovr_set |=> dor_sticky_reg || (count_reg != 2'h0))
		else $error("overrun not recorded");
	a_overrun_clear: assert property ((push && !ovr_set) |=> !dor_sticky_reg)
		else $error("overrun not cleared on transfer");
	a_status_ro: assert property (
		(wr_in && (addr_in == `OFS_STATUS_A) && !push) |=> $stable(buf_mem[0]) && $stable(buf_mem[1]))
		else $error("status write changed error flags");
	a_parity_off: assert property (
		((state_reg == ST_START) && !parity_mode_high) |-> !par_err_reg)
		else $error("parity error without checking");

	c_overrun: cover property (ovr_set);
	c_noise: cover property ((state_reg == ST_START) && decide && bit_val);
	c_parity_err: cover property (push && pend_reg.pe);
	c_buffer_full: cover property (count_reg == `BUF_DEPTH);

endmodule : uart_async_receiver

// file: hw/uart_rx_defs.svh
/*
 * Register offsets, field positions, reset values and sampling counts
 * for the asynchronous receiver.
 * Assumes it is included by bare name after the type package.
 */
`ifndef UART_RX_DEFS_SVH
`define UART_RX_DEFS_SVH

// Register offsets on the plain register port
`define OFS_STATUS_A    2'h0
`define OFS_CONTROL_B   2'h1
`define OFS_CONTROL_C   2'h2
`define OFS_DATA        2'h3

// Status register a fields
`define BIT_RXC         7
`define BIT_FE          4
`define BIT_DOR         3
`define BIT_UPE         2
`define BIT_U2X         1

// Control register b fields
`define BIT_RXCIE       7
`define BIT_RXEN        4

// Control register c fields
`define BIT_PM_HI       5
`define BIT_PM_LO       4
`define BIT_SBS         3
`define BIT_CSZ_HI      2
`define BIT_CSZ_LO      1

// Reset values
`define RST_STATUS_A    8'h00
`define RST_CONTROL_B   8'h00
`define RST_CONTROL_C   8'h06

// Sample states per bit and first voting sample
`define SPB_NORMAL      5'h10
`define SPB_DOUBLE      5'h08
`define VOTE_NORMAL     5'h08
`define VOTE_DOUBLE     5'h04

// Receive buffer depth in characters
`define BUF_DEPTH       2'h2

`endif

// file: hw/uart_rx_pkg.sv
/*
 * Types shared by the asynchronous receiver.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package uart_rx_pkg;

	// Frame recovery states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_DATA,
		ST_PARITY,
		ST_STOP
	} rx_state_e;

	// One buffered character with its status
	typedef struct packed {
		logic       fe;
		logic       dor;
		logic       pe;
		logic [7:0] data;
	} rx_entry_s;

endpackage : uart_rx_pkg

// file: test/serial_tx_model.sv
/*
 * Model of the remote asynchronous transmitter on the receive line.
 * Assumes the bench pulses tick_in at the receiver's oversampling rate.
 */
`timescale 1ns/100ps

module serial_tx_model (
	// Clock and oversampling tick
	input  wire logic clk_in,
	input  wire logic tick_in,
	// Serial line towards the receiver
	output logic      line_out
);
	// Line idles high, as a pulled-up line would
	initial line_out = 1'b1;

	// Drive a level for n ticks, changing just after an edge
	task automatic hold(input logic v, input int n);
		@(posedge clk_in);
		line_out <= v;
		repeat (n) @(posedge clk_in iff tick_in);
	endtask : hold

	// One frame: start, data LSB first, optional parity, one stop
	task automatic send(input logic [7:0] d, input int nbits, input logic par_en, input logic odd,
		input logic bad_par, input logic stop_v, input int spb, input int stop_n);
		logic p;
		p = odd;
		hold(1'b0, spb);
		for (int i = 0; i < nbits; i++) begin
			hold(d[i], spb);
			p = p ^ d[i];
		end
		// Parity bit, flipped on demand to provoke an error
		if (par_en) begin
			hold(p ^ bad_par, spb);
		end
		// Short stop lengths let the next start follow early
		hold(stop_v, stop_n);
		if (!stop_v) begin
			hold(1'b1, spb);
		end
	endtask : send
endmodule : serial_tx_model

// file: test/tb_top.sv
/*
 * Self-checking bench for the asynchronous receiver.
 * Assumes the receiver samples every second clock and the remote
 * transmitter model drives the serial line.
 */
`timescale 1ns/100ps
`include "uart_rx_defs.svh"

module tb_top import uart_rx_pkg::*;;
	// Design stimulus and observation
	logic       clk_in         = 1'b0;
	logic       rst_in         = 1'b1;
	logic       sample_tick_in = 1'b0;
	logic       line;
	logic [1:0] addr_in        = 2'h0;
	logic [7:0] wdata_in       = 8'h00;
	logic       wr_in          = 1'b0;
	logic       rd_in          = 1'b0;
	logic [7:0] rdata_out;
	logic       rx_irq_out;
	logic       pin_override_out;
	// Counters
	int         num_errors     = 0;
	int         comparisons    = 0;

	// 20 MHz clock, tick every second cycle
	always #25 clk_in = ~clk_in;
	always @(posedge clk_in) sample_tick_in <= ~sample_tick_in;

	uart_async_receiver uut (
		.clk_in(clk_in), .rst_in(rst_in), .sample_tick_in(sample_tick_in),
		.serial_input_pin_in(line), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.rx_irq_out(rx_irq_out), .pin_override_out(pin_override_out)
	);

	serial_tx_model tx (
		.clk_in(clk_in), .tick_in(sample_tick_in), .line_out(line)
	);

	// One-cycle write strobe
	task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in    <= 1'b0;
	endtask : reg_write

	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in   <= 1'b0;
		#1;
		d = rdata_out;
	endtask : reg_read

	// Byte comparison
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check8

	// Single-bit comparison
	task automatic check1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check1

	// Read a register and compare
	task automatic expect_reg(input logic [1:0] a, input logic [7:0] exp);
		logic [7:0] d;
		reg_read(a, d);
		check8(d, exp);
	endtask : expect_reg

	// Plain 8-bit frame, then let it reach the buffer
	task automatic send8(input logic [7:0] d, input logic stop_v);
		tx.send(d, 8, 1'b0, 1'b0, 1'b0, stop_v, 16, 16);
		repeat (12) @(posedge clk_in);
	endtask : send8

	// Verdict and end of run
	task automatic wrap_up;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	// Watchdog, far beyond the roughly 5000 cycles of traffic
	initial begin
		repeat (40000) @(posedge clk_in);
		num_errors++;
		wrap_up();
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		// Reset values
		expect_reg(`OFS_STATUS_A, 8'h00);
		expect_reg(`OFS_CONTROL_B, 8'h00);
		expect_reg(`OFS_CONTROL_C, 8'h06);
		check1(pin_override_out, 1'b0);
		// Enable with interrupt, one clean frame
		reg_write(`OFS_CONTROL_B, 8'h90);
		repeat (2) @(posedge clk_in);
		check1(pin_override_out, 1'b1);
		send8(8'ha5, 1'b1);
		check1(rx_irq_out, 1'b1);
		expect_reg(`OFS_STATUS_A, 8'h80);
		expect_reg(`OFS_DATA, 8'ha5);
		repeat (3) @(posedge clk_in);
		check1(rx_irq_out, 1'b0);
		expect_reg(`OFS_STATUS_A, 8'h00);
		// Stop bit low; error flags survive a software write of zeros
		reg_write(`OFS_CONTROL_B, 8'h10);
		// Two stop bits selected must not change the framing verdict
		reg_write(`OFS_CONTROL_C, 8'h0e);
		expect_reg(`OFS_CONTROL_C, 8'h0e);
		send8(8'h3c, 1'b0);
		check1(rx_irq_out, 1'b0);
		reg_write(`OFS_STATUS_A, 8'h00);
		expect_reg(`OFS_STATUS_A, 8'h90);
		expect_reg(`OFS_DATA, 8'h3c);
		expect_reg(`OFS_STATUS_A, 8'h00);
		// Even then odd parity: a bad frame followed by a good one
		for (int m = 0; m < 2; m++) begin
			reg_write(`OFS_CONTROL_C, (m != 0) ? 8'h36 : 8'h26);
			tx.send(8'h07, 8, 1'b1, m[0], 1'b1, 1'b1, 16, 16);
			tx.send(8'h07, 8, 1'b1, m[0], 1'b0, 1'b1, 16, 16);
			repeat (12) @(posedge clk_in);
			expect_reg(`OFS_STATUS_A, 8'h84);
			expect_reg(`OFS_DATA, 8'h07);
			expect_reg(`OFS_STATUS_A, 8'h80);
			expect_reg(`OFS_DATA, 8'h07);
		end
		// Five-bit characters mask the upper bits
		reg_write(`OFS_CONTROL_C, 8'h00);
		tx.send(8'hff, 5, 1'b0, 1'b0, 1'b0, 1'b1, 16, 16);
		repeat (12) @(posedge clk_in);
		expect_reg(`OFS_DATA, 8'h1f);
		reg_write(`OFS_CONTROL_C, 8'h06);
		// Short low glitch is rejected, next frame still lands
		tx.hold(1'b0, 4);
		tx.hold(1'b1, 16);
		send8(8'h5a, 1'b1);
		expect_reg(`OFS_STATUS_A, 8'h80);
		expect_reg(`OFS_DATA, 8'h5a);
		expect_reg(`OFS_STATUS_A, 8'h00);
		// Four back-to-back frames with short stops overrun the buffer
		for (int i = 1; i < 5; i++) begin
			tx.send({4'(i), 4'(i)}, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16, 12);
		end
		repeat (12) @(posedge clk_in);
		expect_reg(`OFS_STATUS_A, 8'h80);
		expect_reg(`OFS_DATA, 8'h11);
		expect_reg(`OFS_STATUS_A, 8'h80);
		expect_reg(`OFS_DATA, 8'h22);
		expect_reg(`OFS_STATUS_A, 8'h88);
		expect_reg(`OFS_DATA, 8'h33);
		expect_reg(`OFS_STATUS_A, 8'h00);
		send8(8'h55, 1'b1);
		expect_reg(`OFS_STATUS_A, 8'h80);
		expect_reg(`OFS_DATA, 8'h55);
		// Double speed: eight samples per bit
		reg_write(`OFS_STATUS_A, 8'h02);
		expect_reg(`OFS_STATUS_A, 8'h02);
		tx.send(8'hc3, 8, 1'b0, 1'b0, 1'b0, 1'b1, 8, 8);
		repeat (12) @(posedge clk_in);
		expect_reg(`OFS_STATUS_A, 8'h82);
		expect_reg(`OFS_DATA, 8'hc3);
		reg_write(`OFS_STATUS_A, 8'h00);
		// Disable flushes an unread character and releases the pin
		send8(8'h99, 1'b1);
		reg_write(`OFS_CONTROL_B, 8'h00);
		repeat (2) @(posedge clk_in);
		check1(pin_override_out, 1'b0);
		expect_reg(`OFS_STATUS_A, 8'h00);
		// Disable in mid-frame abandons the reception
		reg_write(`OFS_CONTROL_B, 8'h10);
		fork
			send8(8'h66, 1'b1);
			begin
				repeat (100) @(posedge clk_in);
				reg_write(`OFS_CONTROL_B, 8'h00);
			end
		join
		reg_write(`OFS_CONTROL_B, 8'h10);
		expect_reg(`OFS_STATUS_A, 8'h00);
		wrap_up();
	end
endmodule : tb_top
